// file: bench/cmc_port_checker.sv
`timescale 1ns/100ps
`include "cmc_defines.svh"
module cmc_port_checker (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        reconfigRequestN,
  input wire logic        detectEnable,
  input wire logic        cfgDone,
  input wire logic [9:0]  jtagInstr,
  input wire logic        configStateN,
  input wire logic        crcErrorOut,
  input wire logic        crcErrorOe,
  input wire logic        jtagTdo,
  input wire logic [31:0] signatureOut,
  input wire logic        userMode
);
  logic [1:0] settleCnt_q;
  // Design reset lags the reconfiguration pin by its synchroniser
  always_ff @(posedge mclk) begin
    if (reset || !reconfigRequestN) begin
      settleCnt_q <= 2'h3;
    end else if (settleCnt_q != 2'h0) begin
      settleCnt_q <= settleCnt_q - 2'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset || !reconfigRequestN || settleCnt_q != 2'h0);
  property p_flagSet; |signatureOut && detectEnable |-> ##[0:1] crcErrorOut;
  endproperty
  a_flagSet: assert property (p_flagSet) else $error("flag low");
  property p_flagClr; signatureOut == 0 |-> ##[0:1] !crcErrorOut; endproperty
  a_flagClr: assert property (p_flagClr) else $error("flag high");
  property p_oe; 1 |=> crcErrorOe == $past(detectEnable); endproperty
  a_oe: assert property (p_oe) else $error("enable wrong");
  property p_sigHold; $changed(signatureOut) |=> $stable(signatureOut)[*8];
  endproperty
  a_sigHold: assert property (p_sigHold) else $error("sig moved");
  property p_cfgSticky; !configStateN |=> !configStateN; endproperty
  a_cfgSticky: assert property (p_cfgSticky) else $error("state");
  property p_userStays; userMode |=> userMode; endproperty
  a_userStays: assert property (p_userStays) else $error("left user");
  property p_userEntry; $rose(userMode) |-> $past(cfgDone) || $past(cfgDone, 2);
  endproperty
  a_userEntry: assert property (p_userEntry) else $error("entry");
  property p_tdoIdle; jtagInstr != `CMC_LOAD_REF_INSTR [*5] |-> !jtagTdo;
  endproperty
  a_tdoIdle: assert property (p_tdoIdle) else $error("tdo busy");
endmodule
bind cmc_crc_checker cmc_port_checker u_chk (.mclk, .reset, .reconfigRequestN,
  .detectEnable, .cfgDone, .jtagInstr, .configStateN, .crcErrorOut,
  .crcErrorOe, .jtagTdo, .signatureOut, .userMode);

// file: bench/cmc_supervisor_model.sv
`timescale 1ns/100ps
module cmc_supervisor_model #(
  parameter int DELAY = 10
) (
  input  wire logic mclk,
  input  wire logic errorPin,
  input  wire logic reactOnError,
  output logic      reconfigRequestN
);
  int hold = 0;
  // Strobe low for 9 cycles after a reaction delay
  assign reconfigRequestN = !(hold inside {[1:9]});
  always @(posedge mclk) begin
    if (hold > 0) hold <= hold - 1;
    else if (reactOnError && errorPin) hold <= DELAY + 9;
  end
endmodule

// file: bench/tb.sv
`timescale 1ns/100ps
`include "cmc_defines.svh"
module tb
  import cmc_pkg::*;
;
  logic mclk = 1'b0, reset = 1'b1, detectEnable = 1'b1, react = 1'b0;
  logic [7:0] frameWords = 8'h03;
  cmc_word_type cfgWord = '0;
  cmc_jtag_type jtagIn = '0;
  logic cfgDone = 1'b0, jtagShiftDr = 1'b0, jtagUpdateDr = 1'b0;
  logic upsetWe = 1'b0;
  logic [9:0] jtagInstr = 10'h000;
  logic [5:0] upsetAddr = 6'h00;
  logic [31:0] upsetData = 32'h0000_0000, mem [64], ref0, crc;
  wire logic reconfigRequestN, configStateN, crcErrorOut, crcErrorOe;
  wire logic jtagTdo, userMode;
  wire logic [31:0] signatureOut;
  wire logic errorPin = crcErrorOe ? crcErrorOut : 1'b1;
  int failCount = 0, comparisons = 0;
  cmc_crc_checker dut (.mclk, .reset, .detectEnable, .reconfigRequestN,
    .frameWords, .cfgWord, .cfgDone, .jtagIn, .jtagInstr, .jtagShiftDr,
    .jtagUpdateDr, .upsetWe, .upsetAddr, .upsetData, .configStateN,
    .crcErrorOut, .crcErrorOe, .jtagTdo, .signatureOut, .userMode);
  cmc_supervisor_model sup (.mclk, .errorPin, .reactOnError(react),
    .reconfigRequestN);
  initial forever #12.5 mclk = ~mclk;
  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  function automatic logic [31:0] crcw(logic [31:0] c, d, p, int top);
    for (int i = 31; i >= 0; i--) c = (c << 1) ^ ((c[top] ^ d[i]) ? p : 0);
    return c;
  endfunction
  function automatic logic [31:0] memCrc();
    logic [31:0] c = 32'hFFFF_FFFF;
    for (int i = 0; i < 64; i++) c = crcw(c, mem[i], 32'h04C1_1DB7, 31);
    return c;
  endfunction
  task automatic frame(input logic [15:0] bad);
    logic [31:0] c = 32'h0000_FFFF;
    for (int i = 0; i < 3; i++) begin
      c = crcw(c, 32'h1111_00A5 * i, 32'h0000_8005, 15);
      cfgWord <= '{1'b1, 32'h1111_00A5 * i};
      cyc(1);
    end
    cfgWord <= '{1'b1, {16'h0000, c[15:0] ^ bad}};
    cyc(1);
    cfgWord <= '0;
    cyc(3);
  endtask
  task automatic poke(input logic [5:0] a, input logic [31:0] d);
    mem[a] = d;
    upsetWe <= 1'b1;
    upsetAddr <= a;
    upsetData <= d;
    cyc(1);
    upsetWe <= 1'b0;
    cyc(1);
  endtask
  task automatic jtagLoad(input logic [31:0] v, old);
    jtagShiftDr <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      jtagIn <= '{1'b0, 1'b0, v[i]};
      cyc(5);
      chk(32'(jtagTdo), 32'(old[i]));
      jtagIn.tck <= 1'b1;
      cyc(5);
    end
    jtagIn <= '0;
    jtagShiftDr <= 1'b0;
    cyc(5);
    jtagUpdateDr <= 1'b1;
    cyc(5);
    jtagUpdateDr <= 1'b0;
  endtask
  initial begin
    #200_000;
    failCount++;
    summarize();
  end
  initial begin
    cyc(6);
    reset <= 1'b0;
    cyc(1);
    frame(16'h0000);
    chk(32'(configStateN), 32'h0000_0001);
    frame(16'h0040);
    chk(32'(configStateN), 32'h0000_0000);
    reset <= 1'b1;
    cyc(2);
    reset <= 1'b0;
    cyc(1);
    frame(16'h0000);
    ref0 = 32'h1234_5678;
    cfgWord.data <= ref0;
    cfgDone <= 1'b1;
    cyc(1);
    cfgDone <= 1'b0;
    cyc(4);
    chk(32'(userMode), 32'h0000_0001);
    for (int i = 0; i < 64; i++) poke(6'(i), 32'h9E37_79B9 * i);
    cyc(200);
    chk(signatureOut, memCrc() ^ ref0);
    chk(32'(errorPin), 32'(|(memCrc() ^ ref0)));
    crc = memCrc();
    jtagInstr <= `CMC_LOAD_REF_INSTR;
    cyc(10);
    jtagLoad(crc, ref0);
    cyc(200);
    chk(signatureOut, 32'h0000_0000);
    chk(32'(errorPin), 32'h0000_0000);
    chk(32'(userMode), 32'h0000_0001);
    poke(6'h05, mem[5] ^ 32'h0000_0100);
    cyc(200);
    chk(signatureOut, memCrc() ^ crc);
    chk(32'(errorPin), 32'h0000_0001);
    detectEnable <= 1'b0;
    cyc(3);
    chk(32'(crcErrorOe), 32'h0000_0000);
    chk(32'(crcErrorOut), 32'h0000_0000);
    detectEnable <= 1'b1;
    cyc(3);
    chk(32'(errorPin), 32'h0000_0001);
    poke(6'h05, mem[5] ^ 32'h0000_0100);
    cyc(200);
    chk(32'(errorPin), 32'h0000_0000);
    poke(6'h3F, 32'h0000_0000);
    react <= 1'b1;
    cyc(300);
    chk(32'(userMode), 32'h0000_0000);
    summarize();
  end
endmodule

// file: rtl/cmc_config_ram.sv
`timescale 1ns/100ps
`include "cmc_defines.svh"

module cmc_config_ram (
  input  wire logic                       mclk,
  input  wire logic                       wrEn,
  input  wire logic [`CMC_MEM_ADDR_W-1:0] wrAddr,
  input  wire logic [31:0]                wrData,
  input  wire logic [`CMC_MEM_ADDR_W-1:0] rdAddr,
  output logic      [31:0]                rdData
);
  logic [31:0] mem [`CMC_MEM_WORDS];

  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge mclk) begin
    rdData <= mem[rdAddr];
  end
endmodule

// file: rtl/cmc_crc_checker.sv
`timescale 1ns/100ps
`include "cmc_defines.svh"

// Notes on behaviour
// - Keep a 32-bit reference from configuration; recheck memory forever.
// - One 32-bit CRC covers the whole configuration memory.
// - Error flag high means corrupted memory found; low means clean or detectEnable low.
// - Each frame is followed by its 16-bit CRC, checked while calculated.
// - Frame CRC mismatch drives config_state_n low.
// - Frame length is a device-specific setting, not fixed.
// - Two 32-bit registers: signature and reference.
// - Signature is zero when clean, non-zero when corrupted.
// - Error flag is high whenever the signature is non-zero and detectEnable is high.
// - Reference loaded from the stream at end of configuration.
// - Reference feeds the compare unit on every pass.
// - Load-reference instruction makes reference a 32-bit scan chain.
// - Scanned-in reference changes the checked value, enabling injection.
// - Reference rewrite does not halt checking or user logic.
// - Load-reference instruction code is 10'b00_0001_0101.
// - Flag holds through the next pass; cleared by a clean pass or by detectEnable low.
// - Generator is the IEEE 802 32-bit polynomial.
// - Checking runs until reconfig_request_n resets the device.

module cmc_crc_checker
  import cmc_pkg::*;
(
  input  wire logic                       mclk,
  input  wire logic                       reset,
  input  wire logic                       detectEnable,
  input  wire logic                       reconfigRequestN,
  input  wire logic [`CMC_FRAME_CNT_W-1:0] frameWords,
  input  wire cmc_word_type               cfgWord,
  input  wire logic                       cfgDone,
  input  wire cmc_jtag_type               jtagIn,
  input  wire logic [`CMC_IR_WIDTH-1:0]   jtagInstr,
  input  wire logic                       jtagShiftDr,
  input  wire logic                       jtagUpdateDr,
  input  wire logic                       upsetWe,
  input  wire logic [`CMC_MEM_ADDR_W-1:0] upsetAddr,
  input  wire logic [31:0]                upsetData,
  output logic                            configStateN,
  output logic                            crcErrorOut,
  output logic                            crcErrorOe,
  output logic                            jtagTdo,
  output logic [31:0]                     signatureOut,
  output logic                            userMode
);
  function automatic logic [31:0] crc32Word(logic [31:0] c, logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? `CMC_CRC32_POLY : 32'h0000_0000);
    end
    return r;
  endfunction

  function automatic logic [15:0] crc16Word(logic [15:0] c, logic [31:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? `CMC_CRC16_POLY : 16'h0000);
    end
    return r;
  endfunction

  // Pin and JTAG inputs resynchronised
  logic [1:0] rcfgSync_q, tckSync_q, tdiSync_q, shSync_q, upSync_q;
  logic       tckPrev_q, upPrev_q, shPrev_q;
  // Instruction is quasi-static; used only once two samples agree
  logic [`CMC_IR_WIDTH-1:0] irSync_q [2];
  logic [`CMC_IR_WIDTH-1:0] irHold_q;
  always_ff @(posedge mclk) begin
    rcfgSync_q <= {rcfgSync_q[0], reconfigRequestN};
    tckSync_q  <= {tckSync_q[0], jtagIn.tck};
    tdiSync_q  <= {tdiSync_q[0], jtagIn.tdi};
    shSync_q   <= {shSync_q[0], jtagShiftDr};
    upSync_q   <= {upSync_q[0], jtagUpdateDr};
    tckPrev_q  <= tckSync_q[1];
    upPrev_q   <= upSync_q[1];
    shPrev_q   <= shSync_q[1];
    irSync_q[0] <= jtagInstr;
    irSync_q[1] <= irSync_q[0];
    irHold_q    <= irSync_q[1];
  end

  logic tckRise, updRise, shRise, instrSel, rstAll;
  assign tckRise  = tckSync_q[1] & ~tckPrev_q;
  assign updRise  = upSync_q[1] & ~upPrev_q;
  assign shRise   = shSync_q[1] & ~shPrev_q;
  assign instrSel = (irSync_q[1] == irHold_q) &&
                    (irHold_q == `CMC_LOAD_REF_INSTR);
  assign rstAll   = reset | ~rcfgSync_q[1];

  cmc_state_type state_q;
  logic [`CMC_FRAME_CNT_W-1:0] wordCnt_q;
  logic [15:0] frameCrc_q;
  logic [`CMC_MEM_ADDR_W-1:0] loadAddr_q, scanAddr_q;
  logic [31:0] ramData;
  logic        ramWe;
  logic [`CMC_MEM_ADDR_W-1:0] ramWa;
  logic [31:0] ramWd;

  assign ramWe = (state_q == CMC_ST_CONFIG && cfgWord.valid) | upsetWe;
  assign ramWa = upsetWe ? upsetAddr : loadAddr_q;
  assign ramWd = upsetWe ? upsetData : cfgWord.data;

  cmc_config_ram uRam (
    .mclk  (mclk),
    .wrEn  (ramWe),
    .wrAddr(ramWa),
    .wrData(ramWd),
    .rdAddr(scanAddr_q),
    .rdData(ramData)
  );

  // Configuration load and per-frame CRC
  always_ff @(posedge mclk) begin
    if (rstAll) begin
      state_q    <= CMC_ST_CONFIG;
      wordCnt_q  <= '0;
      frameCrc_q <= `CMC_CRC16_INIT;
      loadAddr_q <= '0;
    end else begin
      case (state_q)
        CMC_ST_CONFIG: begin
          if (cfgDone) begin
            state_q <= CMC_ST_USER;
          end else if (cfgWord.valid) begin
            frameCrc_q <= crc16Word(frameCrc_q, cfgWord.data);
            loadAddr_q <= loadAddr_q + 1'b1;
            if (wordCnt_q == frameWords - 1'b1) begin
              wordCnt_q <= '0;
              state_q   <= CMC_ST_FRAME_CRC;
            end else begin
              wordCnt_q <= wordCnt_q + 1'b1;
            end
          end
        end
        CMC_ST_FRAME_CRC: begin
          if (cfgWord.valid) begin
            frameCrc_q <= `CMC_CRC16_INIT;
            if (cfgWord.data[15:0] != frameCrc_q) begin
              state_q <= CMC_ST_HALT;
            end else begin
              state_q <= CMC_ST_CONFIG;
            end
          end
        end
        CMC_ST_USER: state_q <= CMC_ST_USER;
        CMC_ST_HALT: state_q <= CMC_ST_HALT;
        default: state_q <= CMC_ST_CONFIG;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rstAll) begin
      configStateN <= 1'b1;
      userMode     <= 1'b0;
    end else begin
      configStateN <= (state_q != CMC_ST_HALT);
      userMode     <= (state_q == CMC_ST_USER);
    end
  end

  // Reference register and its scan chain
  logic [31:0] refStore_q, refShift_q;
  always_ff @(posedge mclk) begin
    if (rstAll) begin
      refStore_q <= `CMC_REF_RESET;
      refShift_q <= `CMC_REF_RESET;
    end else if (state_q == CMC_ST_CONFIG && cfgDone) begin
      refStore_q <= cfgWord.data;
    end else if (state_q == CMC_ST_USER && instrSel) begin
      // Capture only at shift start, so shifted bits survive to update
      if (shRise) begin
        refShift_q <= refStore_q;
      end else if (shSync_q[1] && tckRise) begin
        refShift_q <= {tdiSync_q[1], refShift_q[31:1]};
      end
      if (updRise) begin
        refStore_q <= refShift_q;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rstAll) begin
      jtagTdo <= 1'b0;
    end else begin
      jtagTdo <= instrSel & refShift_q[0];
    end
  end

  // Continuous full-memory pass
  logic [31:0] runCrc_q, signature_q;
  logic        scanValid_q, lastWord_q;
  always_ff @(posedge mclk) begin
    if (rstAll || state_q != CMC_ST_USER) begin
      scanAddr_q  <= '0;
      scanValid_q <= 1'b0;
      lastWord_q  <= 1'b0;
      runCrc_q    <= `CMC_CRC32_INIT;
    end else begin
      scanAddr_q  <= scanAddr_q + 1'b1;
      scanValid_q <= 1'b1;
      lastWord_q  <= (scanAddr_q == `CMC_MEM_ADDR_W'(`CMC_MEM_WORDS - 1));
      if (scanValid_q) begin
        runCrc_q <= lastWord_q ? `CMC_CRC32_INIT
                               : crc32Word(runCrc_q, ramData);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rstAll) begin
      signature_q <= `CMC_SIG_RESET;
    end else if (scanValid_q && lastWord_q) begin
      signature_q <= crc32Word(runCrc_q, ramData) ^ refStore_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rstAll) begin
      signatureOut <= `CMC_SIG_RESET;
      crcErrorOut  <= 1'b0;
      crcErrorOe   <= 1'b0;
    end else begin
      signatureOut <= signature_q;
      crcErrorOut  <= detectEnable & (|signature_q);
      crcErrorOe   <= detectEnable;
    end
  end
endmodule

// file: rtl/cmc_defines.svh
`ifndef CMC_DEFINES_SVH
`define CMC_DEFINES_SVH

`define CMC_CRC32_POLY     32'h04C1_1DB7
`define CMC_CRC32_INIT     32'hFFFF_FFFF
`define CMC_CRC16_POLY     16'h8005
`define CMC_CRC16_INIT     16'hFFFF
`define CMC_REF_RESET      32'h0000_0000
`define CMC_SIG_RESET      32'h0000_0000
`define CMC_LOAD_REF_INSTR 10'h015
`define CMC_IR_WIDTH       10
`define CMC_MEM_WORDS      64
`define CMC_MEM_ADDR_W     6
`define CMC_FRAME_WORDS    4
`define CMC_FRAME_CNT_W    8

`endif

// file: rtl/cmc_pkg.sv
package cmc_pkg;
  typedef enum logic [1:0] {
    CMC_ST_CONFIG = 2'h0,
    CMC_ST_FRAME_CRC = 2'h1,
    CMC_ST_USER = 2'h2,
    CMC_ST_HALT = 2'h3
  } cmc_state_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } cmc_word_type;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } cmc_jtag_type;
endpackage
